/* hw/dcda_defines.vh */
/*
  constants for the two-channel dma request arbiter: states, widths,
  address window defaults and transfer direction codes.
  assumes inclusion by bare name from the design and dv files.
*/
`ifndef DCDA_DEFINES_VH
`define DCDA_DEFINES_VH

`define DCDA_ADDR_W        20
`define DCDA_DATA_W        8
`define DCDA_CNT_W         10
`define DCDA_RAM_LO        20'hfef00
`define DCDA_RAM_HI        20'hffedf
`define DCDA_GPR_LO        20'hffee0
`define DCDA_GPR_HI        20'hffeff
`define DCDA_DIR_SFR2RAM   1'b0
`define DCDA_DIR_RAM2SFR   1'b1
`define DCDA_ST_IDLE       2'h0
`define DCDA_ST_XFER       2'h1
`define DCDA_ST_DONE       2'h2
`define DCDA_UNDEF_DATA    8'h00
`define DCDA_ONE_ADDR      20'h00001
`define DCDA_ONE_CNT       10'h001

`endif

/* hw/dcda_addr_check.v */
/*
  classifies a ram-side address as usable internal ram or not.
  assumes the ram window and register bank bounds from the header.
*/
`timescale 1ns/1ns
`include "dcda_defines.vh"

module dcda_addr_check
#(
  parameter [`DCDA_ADDR_W-1:0] RAM_LO = `DCDA_RAM_LO,
  parameter [`DCDA_ADDR_W-1:0] RAM_HI = `DCDA_RAM_HI,
  parameter [`DCDA_ADDR_W-1:0] GPR_LO = `DCDA_GPR_LO,
  parameter [`DCDA_ADDR_W-1:0] GPR_HI = `DCDA_GPR_HI
)
(
  input  wire [`DCDA_ADDR_W-1:0] i_addr,
  output wire                    o_valid
);
  wire in_ram;
  wire in_gpr;

  assign in_ram  = (i_addr >= RAM_LO) && (i_addr <= RAM_HI);
  assign in_gpr  = (i_addr >= GPR_LO) && (i_addr <= GPR_HI);
  assign o_valid = in_ram && !in_gpr;
endmodule

/* hw/dcda_skid_buf.v */
/*
  two-entry buffer with valid/ready on both sides.
  assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ns
`include "dcda_defines.vh"

module dcda_skid_buf
#(
  parameter WIDTH = 29
)
(
  input  wire             i_clk_sys,
  input  wire             i_srst,
  input  wire             i_ce,
  input  wire             i_valid,
  output wire             o_ready,
  input  wire [WIDTH-1:0] i_data,
  output wire             o_valid,
  input  wire             i_ready,
  output wire [WIDTH-1:0] o_data
);
  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wptr_reg;
  reg             rptr_reg;
  reg [1:0]       cnt_reg;
  wire            push;
  wire            pop;

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = mem_reg[rptr_reg];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg  <= 2'h0;
    end
    else if (i_ce)
    begin
      if (push)
      begin
        mem_reg[wptr_reg] <= i_data;
        wptr_reg          <= ~wptr_reg;
      end
      if (pop)
        rptr_reg <= ~rptr_reg;
      if (push && !pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
endmodule

/* hw/dcda_arbiter.v */
/*
  two-channel dma request arbiter with ram address stepping.
  assumes requests and cpu status come from logic on i_clk_sys; the
  peripheral data pin path is external and double-synchronised here.
  each granted transfer moves one byte; a channel run lasts its count.
*/
`timescale 1ns/1ns
`include "dcda_defines.vh"

// Notes on behaviour
// - request on idle channel waits while other channel transfers; never dropped
// - waiting request starts only after the active transfer fully completes
// - simultaneous requests: channel 0 granted before channel 1
// - dma grant wins over a same-cycle interrupt; interrupt held back
// - no new grant right after call, table call or break instruction
// - no new grant right after bit ops on irq flag/mask/priority or psw
// - ram address register steps by one on every transfer
// - peripheral-to-ram write to bad ram address is discarded
// - ram-to-peripheral read from bad address returns undefined data
module dcda_arbiter
#(
  parameter ADDR_W = `DCDA_ADDR_W,
  parameter DATA_W = `DCDA_DATA_W,
  parameter CNT_W  = `DCDA_CNT_W
)
(
  input  wire              i_clk_sys,
  input  wire              i_srst,
  input  wire              i_ce,
  input  wire [1:0]        i_req,
  input  wire [1:0]        i_chan_en,
  input  wire [1:0]        i_dir,
  input  wire [ADDR_W-1:0] i_start_addr0,
  input  wire [ADDR_W-1:0] i_start_addr1,
  input  wire [CNT_W-1:0]  i_count0,
  input  wire [CNT_W-1:0]  i_count1,
  input  wire [1:0]        i_load,
  input  wire              i_instr_boundary,
  input  wire              i_call_or_break,
  input  wire              i_irq_reg_bitop,
  input  wire              i_irq_pending,
  input  wire [DATA_W-1:0] i_ram_rdata,
  input  wire [DATA_W-1:0] i_sfr_pin_data,
  input  wire              i_sink_ready,
  output reg               o_busy,
  output reg  [1:0]        o_grant,
  output reg               o_irq_ack_ok,
  output reg  [ADDR_W-1:0] o_ram_addr,
  output reg               o_ram_re,
  output reg               o_xfer_valid,
  output reg               o_xfer_ram_we,
  output reg  [ADDR_W-1:0] o_xfer_addr,
  output reg  [DATA_W-1:0] o_xfer_data,
  output reg               o_xfer_chan,
  output reg  [1:0]        o_run_done
)
;
  localparam BUF_W = ADDR_W + DATA_W + 2;

  reg  [1:0]        state_reg;
  reg  [1:0]        state_next;
  reg  [1:0]        pend_reg;
  reg               chan_reg;
  reg               hold_reg;
  reg  [DATA_W-1:0] sfr_s1_reg;
  reg  [DATA_W-1:0] sfr_s2_reg;
  reg  [ADDR_W-1:0] dma_ram_address_reg [0:1];
  reg  [CNT_W-1:0]  remain_reg [0:1];
  reg               issue_reg;
  reg  [DATA_W-1:0] wdata;
  reg               we_ok;

  wire [ADDR_W-1:0] cur_addr;
  wire              addr_ok;
  wire              buf_ready;
  wire              buf_valid;
  wire [BUF_W-1:0]  buf_out;
  wire [1:0]        live;
  wire              may_grant;
  wire              pick;
  wire              start;
  wire              boundary_hold;
  wire              out_take;

  assign cur_addr = dma_ram_address_reg[chan_reg];
  assign live     = (pend_reg | i_req) & i_chan_en;
  assign boundary_hold = i_call_or_break || i_irq_reg_bitop;
  // hold from the instruction just retired lasts until the next boundary
  assign may_grant = i_instr_boundary && !boundary_hold &&
                     !hold_reg;
  assign pick  = live[0] ? 1'b0 : 1'b1;
  assign start = (state_reg == `DCDA_ST_IDLE) && may_grant &&
                 (live != 2'b00);
  // buffer pops only when the output stage really takes its word,
  // else a stalled sink would see the same word twice
  assign out_take = !o_xfer_valid || i_sink_ready;

  dcda_addr_check u_chk
  (
    .i_addr  (cur_addr),
    .o_valid (addr_ok)
  );

  // pin data crosses in from the peripheral side
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      sfr_s1_reg <= {DATA_W{1'b0}};
      sfr_s2_reg <= {DATA_W{1'b0}};
    end
    else if (i_ce)
    begin
      sfr_s1_reg <= i_sfr_pin_data;
      sfr_s2_reg <= sfr_s1_reg;
    end
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `DCDA_ST_IDLE:
        if (start)
          state_next = `DCDA_ST_XFER;
      `DCDA_ST_XFER:
        if (buf_ready)
          state_next = `DCDA_ST_DONE;
      `DCDA_ST_DONE:
        state_next = `DCDA_ST_IDLE;
      default:
        state_next = `DCDA_ST_IDLE;
    endcase
  end

  always @*
  begin
    we_ok = 1'b0;
    wdata = sfr_s2_reg;
    if (i_dir[chan_reg] == `DCDA_DIR_SFR2RAM)
      we_ok = addr_ok;
    else if (addr_ok)
      wdata = i_ram_rdata;
    else
      wdata = `DCDA_UNDEF_DATA;
  end

  dcda_skid_buf #(.WIDTH(BUF_W)) u_buf
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_ce      (i_ce),
    .i_valid   (state_reg == `DCDA_ST_XFER),
    .o_ready   (buf_ready),
    .i_data    ({chan_reg, we_ok, cur_addr, wdata}),
    .o_valid   (buf_valid),
    .i_ready   (out_take),
    .o_data    (buf_out)
  );

  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      state_reg <= `DCDA_ST_IDLE;
      pend_reg  <= 2'b00;
      chan_reg  <= 1'b0;
      hold_reg  <= 1'b0;
      issue_reg <= 1'b0;
      dma_ram_address_reg[0] <= {ADDR_W{1'b0}};
      dma_ram_address_reg[1] <= {ADDR_W{1'b0}};
      remain_reg[0] <= {CNT_W{1'b0}};
      remain_reg[1] <= {CNT_W{1'b0}};
      o_busy        <= 1'b0;
      o_grant       <= 2'b00;
      o_irq_ack_ok  <= 1'b0;
      o_ram_addr    <= {ADDR_W{1'b0}};
      o_ram_re      <= 1'b0;
      o_xfer_valid  <= 1'b0;
      o_xfer_ram_we <= 1'b0;
      o_xfer_addr   <= {ADDR_W{1'b0}};
      o_xfer_data   <= {DATA_W{1'b0}};
      o_xfer_chan   <= 1'b0;
      o_run_done    <= 2'b00;
    end
    else if (i_ce)
    begin
      state_reg  <= state_next;
      o_run_done <= 2'b00;
      // hold set by instruction kind off a boundary, cleared at any boundary
      if (i_instr_boundary)
        hold_reg <= 1'b0;
      else if (boundary_hold)
        hold_reg <= 1'b1;
      // requests latch; a start clears the granted channel's latch even if it is set again that cycle
      pend_reg <= live;
      if (start)
      begin
        chan_reg <= pick;
        pend_reg[pick] <= 1'b0;
        if (pick)
          pend_reg[0] <= live[0];
        else
          pend_reg[1] <= live[1];
      end
      if (i_load[0])
      begin
        dma_ram_address_reg[0] <= i_start_addr0;
        remain_reg[0]          <= i_count0;
      end
      if (i_load[1])
      begin
        dma_ram_address_reg[1] <= i_start_addr1;
        remain_reg[1]          <= i_count1;
      end
      if (state_reg == `DCDA_ST_XFER && buf_ready)
      begin
        dma_ram_address_reg[chan_reg] <= cur_addr +
                                         `DCDA_ONE_ADDR;
        remain_reg[chan_reg] <= remain_reg[chan_reg] - `DCDA_ONE_CNT;
        if (remain_reg[chan_reg] == `DCDA_ONE_CNT)
          o_run_done[chan_reg] <= 1'b1;
      end
      issue_reg    <= start;
      o_busy       <= (state_next != `DCDA_ST_IDLE);
      o_grant      <= start ? (pick ? 2'b10 : 2'b01) : 2'b00;
      // interrupt yields to a dma start or transfer in progress
      o_irq_ack_ok <= i_irq_pending && !start &&
                      (state_next == `DCDA_ST_IDLE);
      o_ram_addr   <= start ? dma_ram_address_reg[pick] : cur_addr;
      // strobe stands through a stalled transfer so read data stays valid
      if (start)
        o_ram_re <= (i_dir[pick] == `DCDA_DIR_RAM2SFR);
      else
        o_ram_re <= o_ram_re && (state_next == `DCDA_ST_XFER);
      if (out_take)
      begin
        o_xfer_valid  <= buf_valid;
        o_xfer_chan   <= buf_out[BUF_W-1];
        o_xfer_ram_we <= buf_out[BUF_W-2];
        o_xfer_addr   <= buf_out[ADDR_W+DATA_W-1:DATA_W];
        o_xfer_data   <= buf_out[DATA_W-1:0];
      end
      else
        o_xfer_valid <= 1'b1;
    end
  end
endmodule

/* dv/dcda_arbiter_asserts.sv */
/* port checker for the two-channel dma request arbiter.
   assumes binding onto dcda_arbiter, one clock, sync reset. */
`timescale 1ns/1ns
`include "dcda_defines.vh"
module dcda_chk
(
  input wire        i_clk_sys,
  input wire        i_srst,
  input wire [1:0]  i_dir,
  input wire        i_instr_boundary,
  input wire        i_call_or_break,
  input wire        i_irq_reg_bitop,
  input wire        i_sink_ready,
  input wire        o_busy,
  input wire [1:0]  o_grant,
  input wire        o_irq_ack_ok,
  input wire        o_xfer_valid,
  input wire        o_xfer_ram_we,
  input wire [19:0] o_xfer_addr,
  input wire [7:0]  o_xfer_data,
  input wire        o_xfer_chan
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  wire any_grant = o_grant != 2'h0;
  grant_onehot_a: assert property ($onehot0(o_grant))
    else $error("both channels granted");
  grant_spacing_a: assert property (any_grant |=> !any_grant [*2])
    else $error("grant too soon after grant");
  grant_busy_a: assert property (any_grant |-> o_busy)
    else $error("grant without busy");
  irq_behind_a: assert property (o_busy |-> !o_irq_ack_ok)
    else $error("interrupt allowed during transfer");
  boundary_hold_a: assert property (i_instr_boundary &&
    (i_call_or_break || i_irq_reg_bitop) |=> !any_grant)
    else $error("grant at held boundary");
  boundary_only_a: assert property (any_grant |-> $past(i_instr_boundary))
    else $error("grant off boundary");
  word_follows_a: assert property (any_grant |-> ##[1:6] o_xfer_valid)
    else $error("granted word missing");
  stall_keep_a: assert property (o_xfer_valid && !i_sink_ready |=>
    o_xfer_valid && $stable(o_xfer_addr) && $stable(o_xfer_data))
    else $error("stalled word changed");
  ram_window_a: assert property (o_xfer_valid && o_xfer_ram_we &&
    !i_dir[o_xfer_chan] |-> o_xfer_addr >= `DCDA_RAM_LO &&
    o_xfer_addr <= `DCDA_RAM_HI)
    else $error("ram write outside ram");
  cover property (o_xfer_valid && !i_sink_ready);
  cover property (i_instr_boundary && i_call_or_break);
  cover property (o_grant == 2'h2);
endmodule

/* dv/dcda_far_model.sv */
/* far side: ram answering reads and a word sink that can stall.
   assumes ram data is taken in the strobe cycle. */
`timescale 1ns/1ns
module dcda_far_model
(
  input  wire        i_clk_sys,
  input  wire        i_stall,
  input  wire [19:0] i_addr,
  input  wire        i_re,
  output wire [7:0]  o_rdata,
  output wire        o_ready
);
  reg [7:0] junk_reg = 8'h00;
  always @(posedge i_clk_sys)
    junk_reg <= junk_reg + 8'h01;
  // lines wander outside a read so a stale byte never passes
  assign o_rdata = i_re ? (i_addr[7:0] ^ 8'h3c) : junk_reg;
  assign o_ready = !i_stall;
endmodule

/* dv/test_dual_channel_dma_request_arbiter.sv */
/* self-checking bench for the two-channel dma request arbiter.
   assumes the far model for ram and sink, and the port checker. */
`timescale 1ns/1ns
`include "dcda_defines.vh"
module test_dual_channel_dma_request_arbiter;
  reg         i_clk_sys = 1'b0;
  reg         i_srst = 1'b1;
  reg         i_ce = 1'b1;
  reg  [1:0]  i_req = 2'h0;
  reg  [1:0]  i_chan_en = 2'h3;
  reg  [1:0]  i_dir = 2'h0;
  reg  [19:0] i_start_addr0 = 20'h00000;
  reg  [19:0] i_start_addr1 = 20'h00000;
  reg  [9:0]  i_count0 = 10'h000;
  reg  [9:0]  i_count1 = 10'h000;
  reg  [1:0]  i_load = 2'h0;
  reg         i_instr_boundary = 1'b1;
  reg         i_call_or_break = 1'b0;
  reg         i_irq_reg_bitop = 1'b0;
  reg         i_irq_pending = 1'b0;
  reg  [7:0]  i_sfr_pin_data = 8'ha5;
  reg         stall = 1'b0;
  reg  [1:0]  done_seen = 2'h0;
  wire [7:0]  i_ram_rdata;
  wire        i_sink_ready;
  wire        o_busy;
  wire [1:0]  o_grant;
  wire        o_irq_ack_ok;
  wire [19:0] o_ram_addr;
  wire        o_ram_re;
  wire        o_xfer_valid;
  wire        o_xfer_ram_we;
  wire [19:0] o_xfer_addr;
  wire [7:0]  o_xfer_data;
  wire        o_xfer_chan;
  wire [1:0]  o_run_done;
  logic [31:0] got[$];
  integer     n_errors = 0;
  integer     n_tests = 0;
  dcda_arbiter dut (.*);
  dcda_far_model far (.i_clk_sys(i_clk_sys), .i_stall(stall),
    .i_addr(o_ram_addr), .i_re(o_ram_re), .o_rdata(i_ram_rdata),
    .o_ready(i_sink_ready));
  initial
    forever #5 i_clk_sys = ~i_clk_sys;
  // ram2sfr words carry no ram write, so their strobe is masked
  always @(posedge i_clk_sys)
  begin
    if (o_xfer_valid && i_sink_ready)
      got.push_back({2'h0, o_xfer_chan,
        o_xfer_ram_we & ~i_dir[o_xfer_chan], o_xfer_addr, o_xfer_data});
    done_seen <= done_seen | o_run_done;
  end
  task wrap_up;
  begin
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("wrong value %s: expected %h seen %h", what, e, g);
    end
  end
  endtask
  task word(input logic c, input logic we, input logic [19:0] a,
    input logic [7:0] d);
    logic [31:0] w;
  begin
    w = 32'hffffffff;
    repeat (60)
      if (got.size() == 0)
        @(posedge i_clk_sys);
    if (got.size() != 0)
      w = got.pop_front();
    chk("word", {2'h0, c, we, a, d}, w);
  end
  endtask
  task load(input logic [19:0] a0, input logic [19:0] a1,
    input logic [9:0] n);
  begin
    @(posedge i_clk_sys);
    i_dir <= 2'h2;
    i_start_addr0 <= a0;
    i_start_addr1 <= a1;
    i_count0 <= n;
    i_count1 <= 10'h001;
    i_load <= 2'h3;
    @(posedge i_clk_sys);
    i_load <= 2'h0;
  end
  endtask
  task pulse(input logic [1:0] m);
  begin
    @(posedge i_clk_sys);
    i_req <= m;
    @(posedge i_clk_sys);
    i_req <= 2'h0;
  end
  endtask
  task s_prio;
  begin
    load(`DCDA_RAM_LO, 20'hff000, 10'h002);
    pulse(2'h3);
    word(1'b0, 1'b1, `DCDA_RAM_LO, 8'ha5);
    word(1'b1, 1'b0, 20'hff000, 8'h3c);
    pulse(2'h1);
    word(1'b0, 1'b1, 20'hfef01, 8'ha5);
    repeat (4) @(posedge i_clk_sys);
    chk("run done", 32'h3, {30'h0, done_seen});
  end
  endtask
  task s_busy;
  begin
    load(20'hfef10, 20'hff010, 10'h001);
    pulse(2'h2);
    pulse(2'h1);
    word(1'b1, 1'b0, 20'hff010, 8'h2c);
    word(1'b0, 1'b1, 20'hfef10, 8'ha5);
  end
  endtask
  task s_hold;
    integer k;
    logic [1:0] seen;
  begin
    load(20'hfef20, 20'hff020, 10'h002);
    for (k = 0; k < 2; k = k + 1)
    begin
      @(posedge i_clk_sys);
      i_req <= 2'h1;
      i_irq_pending <= 1'b1;
      i_call_or_break <= (k == 0);
      i_irq_reg_bitop <= (k == 1);
      @(posedge i_clk_sys);
      i_req <= 2'h0;
      i_call_or_break <= 1'b0;
      i_irq_reg_bitop <= 1'b0;
      i_instr_boundary <= 1'b0;
      seen = 2'h0;
      repeat (4)
      begin
        @(negedge i_clk_sys);
        seen = seen | o_grant;
      end
      chk("held grant", 32'h0, {30'h0, seen});
      @(posedge i_clk_sys);
      i_instr_boundary <= 1'b1;
      repeat (20)
        if (o_grant == 2'h0)
          @(negedge i_clk_sys);
      chk("irq at grant", 32'h0, {31'h0, o_irq_ack_ok});
      word(1'b0, 1'b1, 20'hfef20 + k, 8'ha5);
      repeat (10)
        if (o_irq_ack_ok !== 1'b1)
          @(negedge i_clk_sys);
      chk("irq after", 32'h1, {31'h0, o_irq_ack_ok});
      i_irq_pending <= 1'b0;
    end
  end
  endtask
  task s_bad;
  begin
    load(`DCDA_GPR_LO, 20'hfeeff, 10'h001);
    stall <= 1'b1;
    pulse(2'h3);
    repeat (12) @(posedge i_clk_sys);
    chk("stalled", 32'h0, got.size());
    stall <= 1'b0;
    word(1'b0, 1'b0, `DCDA_GPR_LO, 8'ha5);
    word(1'b1, 1'b0, 20'hfeeff, `DCDA_UNDEF_DATA);
  end
  endtask
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    s_prio;
    s_busy;
    s_hold;
    s_bad;
    wrap_up;
  end
  // all scenarios fit well inside this span
  initial
  begin
    repeat (3000) @(posedge i_clk_sys);
    n_errors = n_errors + 1;
    wrap_up;
  end
endmodule
bind dcda_arbiter dcda_chk chk_i (.*);
